// file: design/fdt_counter.sv
`timescale 1ns/1ps
module fdt_counter import fdt_pkg::*; #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic active,
  input wire logic fetch,
  input wire logic sleeping,
  input wire logic clear,
  input wire logic [WIDTH-1:0] matchValue,
  // Status
  output logic [WIDTH-1:0] count,
  output logic expired
);
  if (WIDTH != 32) begin : g_width_check
    $error("counter width must be 32");
  end
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  always_comb begin
    count_d = count_q;
    if (!active || clear) begin
      count_d = '0; // RULE15
    end else if (fetch && !sleeping && count_q != matchValue) begin
      count_d = count_q + 1'b1; // RULE2 RULE3
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
  assign count = count_q;
  assign expired = active && (count_q == matchValue); // RULE5

  property p_hold_sleep;
    @(posedge clk) disable iff (rst)
      (active && sleeping && !clear) |=> (count_q == $past(count_q));
  endproperty
  a_hold_sleep: assert property (p_hold_sleep) else $error("count moved in sleep"); // RULE3

  property p_step;
    @(posedge clk) disable iff (rst)
      (active && fetch && !sleeping && !clear && count_q != matchValue)
        |=> (count_q == $past(count_q) + 1);
  endproperty
  a_step: assert property (p_step) else $error("count did not step"); // RULE2

  property p_zero_off;
    @(posedge clk) disable iff (rst) !active |=> count_q == '0;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("count not zero when off"); // RULE15
endmodule

// file: design/fdt_deadman.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - A processor reset is issued when the count reaches the match value.
// RULE2 - The count runs on the system clock and advances only on fetch cycles.
// RULE3 - The count holds while the processor sleeps.
// RULE4 - The timer runs from the configuration enable or the software enable bit.
// RULE5 - The count is 32 bits and compared against a 32-bit match value.
// RULE6 - The match value is built from a low and a high 16-bit configuration word.
// RULE7 - The software enable matters only while the configuration enable is 0.
// RULE8 - The enable bit is control bit 15, reset 0, other bits read 0.
// RULE9 - Writing 0x40 into preclear bits 15..8 arms the first clear step.
// RULE10 - The clear register holds an 8-bit key in bits 7..0, reset 0, upper bits read 0.
// RULE11 - Writing 0x08 after a correct first key clears both keys and the count.
// RULE12 - Any other second key sets the bad-second flag, keeps the first key, stores the value.
// RULE13 - A wrong first key sets a readable bad-first flag.
// RULE14 - The event flag sets on expiry or on a bad key written before a count step.
// RULE15 - The count is zero while disabled and restarts from zero after reset.
module fdt_deadman import fdt_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Configuration words and core
  input wire logic config_timer_enable,
  input wire logic [15:0] match_value_low_word,
  input wire logic [15:0] match_value_high_word,
  input wire logic fetchValid,
  input wire logic coreSleep,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Outputs
  output logic cpuReset,
  output logic irq
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic cfgEnSync;
  logic sleepSync;
  fdt_sync2 u_sync_en (.clk(ref_clk), .rst(rst), .asyncIn(config_timer_enable),
    .syncOut(cfgEnSync));
  fdt_sync2 u_sync_sleep (.clk(ref_clk), .rst(rst), .asyncIn(coreSleep),
    .syncOut(sleepSync));

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic swEnable_q, swEnable_d;
  logic [7:0] preKey_q, preKey_d;
  logic [7:0] clrKey_q, clrKey_d;
  logic bad_first_key_flag_q, bad_first_key_flag_d;
  logic bad_second_key_flag_q, bad_second_key_flag_d;
  logic event_q, event_d;
  logic stepped_q, stepped_d;
  logic [IRQ_W-1:0] irqStat_q, irqStat_d;
  logic [IRQ_W-1:0] irqEn_q, irqEn_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic irq_q, irq_d;
  logic rstReq_q, rstReq_d;
  logic [2:0] rstCnt_q, rstCnt_d;
  logic expiredLast_q;
  logic waitReq_q, waitReq_d;

  logic active;
  logic [31:0] matchValue;
  logic [31:0] count;
  logic expired;
  logic clearCount;
  logic wrStrobe;
  logic rdStrobe;
  logic hiLanes;
  logic loLanes;

  assign active = cfgEnSync || swEnable_q; // RULE4 RULE7
  assign matchValue = {match_value_high_word, match_value_low_word}; // RULE6
  // One wait cycle; a write lands only on the edge where waitrequest is low
  assign wrStrobe = avs_write && ack_q;
  assign rdStrobe = avs_read && !ack_q;
  assign hiLanes = avs_byteenable[1];
  assign loLanes = avs_byteenable[0];

  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    hit = (a == target);
  endfunction

  // Pulse counter is three bits wide
  if (RESET_PULSE_CYCLES < 1 || RESET_PULSE_CYCLES > 8) begin : g_pulse_check
    $error("reset pulse length out of range");
  end

  fdt_counter #(.WIDTH(32)) u_count (
    .clk(ref_clk),
    .rst(rst),
    .active(active),
    .fetch(fetchValid),
    .sleeping(sleepSync),
    .clear(clearCount),
    .matchValue(matchValue),
    .count(count),
    .expired(expired)
  );

  // ----------------------------------------
  // Key sequence and status
  // ----------------------------------------
  always_comb begin
    swEnable_d = swEnable_q;
    preKey_d = preKey_q;
    clrKey_d = clrKey_q;
    bad_first_key_flag_d = bad_first_key_flag_q;
    bad_second_key_flag_d = bad_second_key_flag_q;
    event_d = event_q;
    stepped_d = stepped_q;
    clearCount = 1'b0;
    irqStat_d = irqStat_q;
    irqEn_d = irqEn_q;
    if (fetchValid && !sleepSync && active) begin
      stepped_d = 1'b1;
    end
    if (wrStrobe && hit(avs_address, ADDR_IRQ_CLR)) begin
      irqStat_d = irqStat_q & ~avs_writedata[IRQ_W-1:0];
    end
    if (wrStrobe && hit(avs_address, ADDR_IRQ_EN) && loLanes) begin
      irqEn_d = avs_writedata[IRQ_W-1:0];
    end
    if (wrStrobe && hit(avs_address, ADDR_CONTROL) && hiLanes) begin
      swEnable_d = avs_writedata[CTRL_ON_BIT]; // RULE8
    end
    if (wrStrobe && hit(avs_address, ADDR_PRECLEAR) && hiLanes) begin
      preKey_d = avs_writedata[PRE_KEY_LSB +: 8]; // RULE9
      if (avs_writedata[PRE_KEY_LSB +: 8] != KEY_STEP_ONE) begin
        bad_first_key_flag_d = 1'b1; // RULE13
        irqStat_d[IRQ_BAD_FIRST_KEY_FLAG] = 1'b1;
        if (!stepped_q) begin
          event_d = 1'b1; // RULE14
        end
      end
    end
    if (wrStrobe && hit(avs_address, ADDR_CLEAR) && loLanes) begin
      if (avs_writedata[7:0] == KEY_STEP_TWO && preKey_q == KEY_STEP_ONE) begin
        preKey_d = KEY_RESET; // RULE11
        clrKey_d = KEY_RESET;
        clearCount = 1'b1;
        stepped_d = 1'b0;
        irqStat_d[IRQ_CLEARED] = 1'b1;
      end else begin
        clrKey_d = avs_writedata[7:0]; // RULE10 RULE12
        bad_second_key_flag_d = 1'b1;
        irqStat_d[IRQ_BAD_SECOND_KEY_FLAG] = 1'b1;
        if (!stepped_q) begin
          event_d = 1'b1; // RULE14
        end
      end
    end
    // Expiry set placed last so it wins over a same-cycle clear
    if (expired && !expiredLast_q) begin
      event_d = 1'b1; // RULE14
      irqStat_d[IRQ_EXPIRE] = 1'b1;
    end
  end

  // ----------------------------------------
  // Processor reset request
  // ----------------------------------------
  always_comb begin
    rstReq_d = rstReq_q;
    rstCnt_d = rstCnt_q;
    if (expired && !expiredLast_q) begin
      rstReq_d = 1'b1; // RULE1
      rstCnt_d = 3'(RESET_PULSE_CYCLES - 1);
    end else if (rstReq_q) begin
      if (rstCnt_q == 3'h0) begin
        rstReq_d = 1'b0;
      end else begin
        rstCnt_d = rstCnt_q - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Read path and bus answer
  // ----------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    ack_d = (avs_read || avs_write) && !ack_q;
    waitReq_d = !ack_d;
    irq_d = |(irqStat_q & irqEn_q);
    if (rdStrobe) begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address)
        ADDR_CONTROL: rdata_d[CTRL_ON_BIT] = swEnable_q; // RULE8
        ADDR_PRECLEAR: rdata_d[PRE_KEY_LSB +: 8] = preKey_q;
        ADDR_CLEAR: rdata_d[7:0] = clrKey_q; // RULE10
        ADDR_STATUS: begin
          rdata_d[STAT_BAD_FIRST_KEY_FLAG_BIT] = bad_first_key_flag_q;
          rdata_d[STAT_BAD_SECOND_KEY_FLAG_BIT] = bad_second_key_flag_q;
          rdata_d[STAT_EVENT_BIT] = event_q;
          rdata_d[STAT_WIN_BIT] = 1'b0;
        end
        ADDR_COUNT: rdata_d = count; // RULE11
        ADDR_IRQ_STAT: rdata_d[IRQ_W-1:0] = irqStat_q;
        ADDR_IRQ_EN: rdata_d[IRQ_W-1:0] = irqEn_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      swEnable_q <= 1'b0;
      preKey_q <= KEY_RESET;
      clrKey_q <= KEY_RESET;
      bad_first_key_flag_q <= 1'b0;
      bad_second_key_flag_q <= 1'b0;
      event_q <= 1'b0;
      stepped_q <= 1'b0;
      irqStat_q <= '0;
      irqEn_q <= '0;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      waitReq_q <= 1'b1;
      irq_q <= 1'b0;
      rstReq_q <= 1'b0;
      rstCnt_q <= 3'h0;
      expiredLast_q <= 1'b0;
    end else begin
      swEnable_q <= swEnable_d;
      preKey_q <= preKey_d;
      clrKey_q <= clrKey_d;
      bad_first_key_flag_q <= bad_first_key_flag_d;
      bad_second_key_flag_q <= bad_second_key_flag_d;
      event_q <= event_d;
      stepped_q <= stepped_d;
      irqStat_q <= irqStat_d;
      irqEn_q <= irqEn_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      waitReq_q <= waitReq_d;
      irq_q <= irq_d;
      rstReq_q <= rstReq_d;
      rstCnt_q <= rstCnt_d;
      expiredLast_q <= expired;
    end
  end

  assign avs_readdata = rdata_q;
  // Waitrequest low only on the acknowledge cycle; registered, not derived from inputs
  assign avs_waitrequest = waitReq_q;
  assign cpuReset = rstReq_q;
  assign irq = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_reset_on_expiry;
    @(posedge ref_clk) disable iff (rst) (expired && !expiredLast_q) |=> cpuReset [*4];
  endproperty
  a_reset_on_expiry: assert property (p_reset_on_expiry) else $error("no cpu reset"); // RULE1

  property p_active;
    @(posedge ref_clk) disable iff (rst)
      (cfgEnSync && !swEnable_q && fetchValid && !sleepSync && !clearCount
        && count != matchValue) |=> (count == $past(count) + 32'h1);
  endproperty
  a_active: assert property (p_active) else $error("config enable ignored"); // RULE7

  property p_good_clear;
    @(posedge ref_clk) disable iff (rst)
      (wrStrobe && hit(avs_address, ADDR_CLEAR) && loLanes && avs_writedata[7:0] == KEY_STEP_TWO
        && preKey_q == KEY_STEP_ONE) |=> (preKey_q == KEY_RESET && clrKey_q == KEY_RESET);
  endproperty
  a_good_clear: assert property (p_good_clear) else $error("keys not cleared"); // RULE11

  property p_bad_two;
    @(posedge ref_clk) disable iff (rst)
      (wrStrobe && hit(avs_address, ADDR_CLEAR) && loLanes
        && !(avs_writedata[7:0] == KEY_STEP_TWO && preKey_q == KEY_STEP_ONE))
        |=> (bad_second_key_flag_q && preKey_q == $past(preKey_q) && clrKey_q == $past(avs_writedata[7:0]));
  endproperty
  a_bad_two: assert property (p_bad_two) else $error("bad second key mishandled"); // RULE12

  property p_bad_one;
    @(posedge ref_clk) disable iff (rst)
      (wrStrobe && hit(avs_address, ADDR_PRECLEAR) && hiLanes
        && avs_writedata[15:8] != KEY_STEP_ONE) |=> bad_first_key_flag_q;
  endproperty
  a_bad_one: assert property (p_bad_one) else $error("bad first key not flagged"); // RULE13

  property p_event;
    @(posedge ref_clk) disable iff (rst) (expired && !expiredLast_q) |=> event_q;
  endproperty
  a_event: assert property (p_event) else $error("event flag missing"); // RULE14

  property p_wait;
    @(posedge ref_clk) disable iff (rst) (avs_read || avs_write) && !ack_q |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus not answered"); // RULE8

  property p_sw_enable;
    @(posedge ref_clk) disable iff (rst) (wrStrobe && hit(avs_address, ADDR_CONTROL) && hiLanes)
      |=> (swEnable_q == $past(avs_writedata[CTRL_ON_BIT]));
  endproperty
  a_sw_enable: assert property (p_sw_enable) else $error("enable bit not stored"); // RULE8
endmodule

// file: design/fdt_sync2.sv
`timescale 1ns/1ps
module fdt_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_q;
  logic stage2_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end
  assign syncOut = stage2_q;
endmodule

// file: inc/fdt_pkg.sv
package fdt_pkg;
  // ----------------------------------------
  // Register map (byte addresses, word aligned)
  // ----------------------------------------
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_PRECLEAR = 5'h04;
  localparam logic [4:0] ADDR_CLEAR = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_COUNT = 5'h10;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h14;
  localparam logic [4:0] ADDR_IRQ_EN = 5'h18;
  localparam logic [4:0] ADDR_IRQ_CLR = 5'h1c;
  // ----------------------------------------
  // Fields and values
  // ----------------------------------------
  localparam int CTRL_ON_BIT = 15;
  localparam int PRE_KEY_LSB = 8;
  localparam int STAT_BAD_FIRST_KEY_FLAG_BIT = 7;
  localparam int STAT_BAD_SECOND_KEY_FLAG_BIT = 6;
  localparam int STAT_EVENT_BIT = 5;
  localparam int STAT_WIN_BIT = 0;
  localparam logic [7:0] KEY_STEP_ONE = 8'h40;
  localparam logic [7:0] KEY_STEP_TWO = 8'h08;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam int IRQ_EXPIRE = 0;
  localparam int IRQ_BAD_FIRST_KEY_FLAG = 1;
  localparam int IRQ_BAD_SECOND_KEY_FLAG = 2;
  localparam int IRQ_CLEARED = 3;
  localparam int IRQ_W = 4;
  // Pulse length of the processor reset request
  localparam int RESET_PULSE_CYCLES = 4;
endpackage

// file: test/fdt_core_model.sv
`timescale 1ns/1ps
module fdt_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bench requests
  input wire logic fetchOn,
  input wire logic sleepOn,
  input wire logic leakFetch,
  // Core pins
  input wire logic cpuReset,
  output logic fetchValid,
  output logic coreSleep,
  // Length of the last reset pulse seen
  output int resetLen
);
  int runLen;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fetchValid <= 1'b0;
      coreSleep <= 1'b0;
      runLen <= 0;
      resetLen <= 0;
    end else begin
      // A sleeping core fetches only when a fault is ordered
      fetchValid <= fetchOn && (!sleepOn || leakFetch);
      coreSleep <= sleepOn;
      runLen <= cpuReset ? runLen + 1 : 0;
      if (!cpuReset && runLen != 0) begin
        resetLen <= runLen;
      end
    end
  end
endmodule

// file: test/instruction_fetch_deadman_timer_tb.sv
`timescale 1ns/1ps
module instruction_fetch_deadman_timer_tb;
  import fdt_pkg::*;
  logic ref_clk, rst, cfgEn, fetchOn, sleepOn, leak, fetchValid, coreSleep;
  logic [15:0] matchLo, matchHi;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, cpuReset, irq;
  logic [31:0] avs_writedata, avs_readdata;
  int resetLen, nFail, checksDone;

  fdt_deadman uut (.ref_clk(ref_clk), .rst(rst), .config_timer_enable(cfgEn),
    .match_value_low_word(matchLo), .match_value_high_word(matchHi),
    .fetchValid(fetchValid), .coreSleep(coreSleep), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpuReset(cpuReset), .irq(irq));

  fdt_core_model core (.ref_clk(ref_clk), .rst(rst), .fetchOn(fetchOn), .sleepOn(sleepOn),
    .leakFetch(leak), .cpuReset(cpuReset), .fetchValid(fetchValid),
    .coreSleep(coreSleep), .resetLen(resetLen));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stopTest;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never closes
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic fetchN(input int n);
    @(posedge ref_clk);
    fetchOn <= 1'b1;
    repeat (n) @(posedge ref_clk);
    fetchOn <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic chkIrq(input logic e);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic doReset(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge ref_clk);
    rst <= 1'b1;
    matchLo <= lo;
    matchHi <= hi;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tRegsCount;
    rd(ADDR_CONTROL, 32'h0);
    rd(ADDR_PRECLEAR, 32'h0);
    rd(ADDR_CLEAR, 32'h0);
    fetchN(4);
    rd(ADDR_COUNT, 32'h0);
    wr(ADDR_CONTROL, 32'hffff_ffff);
    rd(ADDR_CONTROL, 32'h0000_8000);
    fetchN(32'h20);
    // Passing the low half alone must not expire
    rd(ADDR_COUNT, 32'h20);
    chk(32'(resetLen), 32'h0);
  endtask

  task automatic tSleep;
    sleepOn <= 1'b1;
    leak <= 1'b1;
    repeat (4) @(posedge ref_clk);
    fetchN(10);
    rd(ADDR_COUNT, 32'h20);
    sleepOn <= 1'b0;
    leak <= 1'b0;
    // Let the wake-up pass the sleep synchroniser
    repeat (4) @(posedge ref_clk);
    fetchN(3);
    rd(ADDR_COUNT, 32'h23);
  endtask

  task automatic tKeys;
    wr(ADDR_IRQ_EN, 32'hf);
    wr(ADDR_PRECLEAR, 32'h4000);
    rd(ADDR_PRECLEAR, 32'h4000);
    wr(ADDR_CLEAR, 32'h8);
    rd(ADDR_COUNT, 32'h0);
    rd(ADDR_PRECLEAR, 32'h0);
    rd(ADDR_CLEAR, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h8);
    chkIrq(1'b1);
    wr(ADDR_IRQ_CLR, 32'h8);
    chkIrq(1'b0);
    fetchN(5);
    wr(ADDR_CONTROL, 32'h0);
    rd(ADDR_COUNT, 32'h0);
  endtask

  task automatic tBadKeys;
    wr(ADDR_CONTROL, 32'h8000);
    fetchN(2);
    wr(ADDR_PRECLEAR, 32'h1100);
    rd(ADDR_STATUS, 32'h80);
    wr(ADDR_PRECLEAR, 32'h4000);
    wr(ADDR_CLEAR, 32'h33);
    rd(ADDR_STATUS, 32'hc0);
    rd(ADDR_PRECLEAR, 32'h4000);
    rd(ADDR_CLEAR, 32'h33);
    rd(ADDR_IRQ_STAT, 32'h6);
    chkIrq(1'b1);
    wr(ADDR_IRQ_EN, 32'h0);
    chkIrq(1'b0);
  endtask

  task automatic tConfig;
    rd(ADDR_STATUS, 32'h0);
    // Bad first key before any count step also raises the event
    wr(ADDR_PRECLEAR, 32'h2200);
    rd(ADDR_STATUS, 32'ha0);
    cfgEn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    fetchN(6);
    rd(ADDR_COUNT, 32'h6);
    cfgEn <= 1'b0;
  endtask

  task automatic tExpire;
    wr(ADDR_IRQ_EN, 32'h1);
    wr(ADDR_CONTROL, 32'h8000);
    fetchN(32'h18);
    rd(ADDR_COUNT, 32'h10);
    chk(32'(resetLen), 32'(RESET_PULSE_CYCLES));
    rd(ADDR_STATUS, 32'h20);
    chkIrq(1'b1);
  endtask

  initial begin
    rst = 1'b1;
    cfgEn = 1'b0;
    fetchOn = 1'b0;
    sleepOn = 1'b0;
    leak = 1'b0;
    matchLo = 16'h0010;
    matchHi = 16'h0001;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    nFail = 0;
    checksDone = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    tRegsCount();
    tSleep();
    tKeys();
    tBadKeys();
    doReset(16'h0010, 16'h0001);
    tConfig();
    doReset(16'h0010, 16'h0000);
    tExpire();
    stopTest();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    stopTest();
  end
endmodule
